//--- tb/cb_model.sv
// Behavioural breaker: per-pole auxiliary contacts and ready signal
module cb_model #(
  parameter int OPN = 2,
  parameter int CLS = 3
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [2:0] trip_pole,
  input  wire logic       close_cmd,
  input  wire logic       hand_close,
  input  wire logic       charged,
  output logic      [2:0] pole_open,
  output logic            cb_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] dly_r;
  // Poles open after a held trip, close after a close order or a manual close
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dly_r     <= 4'h0;
      pole_open <= 3'h0;
    end
    else if (trip_pole != 3'h0 && (pole_open & trip_pole) != trip_pole)
    begin
      dly_r <= dly_r + 4'h1;
      if (dly_r >= 4'(OPN))
        pole_open <= pole_open | trip_pole;
    end
    else if ((close_cmd || hand_close) && trip_pole == 3'h0 && pole_open != 3'h0)
    begin
      dly_r <= dly_r + 4'h1;
      if (dly_r >= 4'(CLS))
        pole_open <= 3'h0;
    end
    else
      dly_r <= 4'h0;
  end
  // Stored energy for one open-close-open cycle, dropped by the bench on demand
  assign cb_ready = charged;
endmodule

//--- tb/reclose_monitor.sv
// Pin-level assertions for the reclose sequencer
module reclose_monitor (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [2:0] fault_phase,
  input wire logic [2:0] pole_open,
  input wire logic [2:0] trip_pole,
  input wire logic       final_trip,
  input wire logic       close_cmd,
  input wire logic       dyn_blocked,
  input wire logic       irq,
  input wire logic       s_axi_bvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Pickup absent long enough to flush the input synchroniser
  sequence quiet_s;
    (fault_phase == 3'h0) [*4];
  endsequence
  final_three_a:
    assert property (final_trip |-> trip_pole == 3'h7)
    else $error("final trip not three-pole");
  close_clean_a:
    assert property ($rose(close_cmd) |-> $past(trip_pole) == 3'h0)
    else $error("close raised while tripping");
  close_holds_a:
    assert property (quiet_s ##0 (close_cmd && pole_open != 3'h0) |=> close_cmd)
    else $error("close dropped with breaker open");
  blocked_no_close_a:
    assert property (dyn_blocked |-> !close_cmd)
    else $error("close while blocked");
  blocked_holds_a:
    assert property (dyn_blocked && !s_axi_bvalid |=> dyn_blocked)
    else $error("block left without a write");
  block_entry_a:
    assert property ($rose(dyn_blocked) |-> $past(fault_phase, 3) == 3'h0)
    else $error("blocked before faults cleared");
  single_not_final_a:
    assert property ($countones(trip_pole) == 1 |-> !final_trip && !dyn_blocked)
    else $error("single-pole trip marked final");
  reset_quiet_a:
    assert property (disable iff (1'b0) rst |=> trip_pole == 3'h0 && !final_trip
                     && !close_cmd && !dyn_blocked && !irq)
    else $error("outputs active after reset");
endmodule
bind auto_reclose_sequencer reclose_monitor u_mon (
  .sys_clk, .rst, .fault_phase, .pole_open, .trip_pole, .final_trip, .close_cmd,
  .dyn_blocked, .irq, .s_axi_bvalid
);

//--- tb/tb.sv
// Self-checking bench for the reclose sequencer
`include "reclose_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [2:0]  fault_phase = 3'h0;
  logic        fault_earth = 1'b0, fault_in_ar_stage = 1'b1, reclose_block = 1'b0;
  logic        hand_close = 1'b0, charged = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic [2:0]  pole_open, trip_pole;
  logic        cb_ready, final_trip, close_cmd, dyn_blocked, irq;
  logic [31:0] tmr [5] = '{32'd2, 32'd8, 32'd14, 32'd20, 32'd20};
  int          n_fail = 0, checked = 0, i, k, n;
  wire  [10:0] obs = {pole_open, irq, dyn_blocked, close_cmd, final_trip, 1'b0, trip_pole};

  auto_reclose_sequencer #(.TICK_CYC(TICK)) DUT (
    .sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fault_phase, .fault_earth,
    .fault_in_ar_stage, .pole_open, .cb_ready, .reclose_block, .trip_pole,
    .final_trip, .close_cmd, .dyn_blocked, .irq
  );
  cb_model u_cb (
    .sys_clk, .rst, .trip_pole, .close_cmd, .hand_close, .charged, .pole_open, .cb_ready
  );

  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int c;
    c = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      c++;
    end
    while (!s_axi_bvalid && c < 50);
    chk({31'h0, s_axi_bvalid}, 32'h1);
    resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    int c;
    c = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      c++;
    end
    while (!s_axi_rvalid && c < 50);
    chk({31'h0, s_axi_rvalid}, 32'h1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rdat & m, e);
  endtask

  task automatic flt(input logic [2:0] p, input logic e);
    fault_phase <= p;
    fault_earth <= e;
  endtask

  // Bounded wait for a pattern on the observed pins, then compare
  task automatic wobs(input logic [10:0] m, input logic [10:0] e);
    int c;
    c = 0;
    while ((obs & m) !== e && c < 400)
    begin
      @(posedge sys_clk);
      c++;
    end
    chk({21'h0, obs & m}, {21'h0, e});
  endtask

  // Stale irq needs two edges to fall after the clear
  task automatic to_idle();
    wr(`AR_OFS_IRQ_ST, 32'hf);
    repeat (2) @(posedge sys_clk);
    wobs(11'h080, 11'h080);
    rchk(`AR_OFS_IRQ_ST, 32'hf, 32'h4);
    rchk(`AR_OFS_STATUS, 32'hffff_0f07, 32'h0);
  endtask

  task automatic unblk();
    wr(`AR_OFS_CMD, 32'h1);
    hand_close <= 1'b1;
    wobs(11'h040, 11'h000);
    wobs(11'h700, 11'h000);
    hand_close <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask

  task automatic end_sim();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog sized well above the expected run
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rchk(`AR_OFS_CTRL, 32'hffff_ffff, `AR_CTRL_RST);
    rchk(`AR_OFS_DEAD1P, 32'hffff, {16'h0, `AR_TIME_RST});
    rchk(`AR_OFS_IRQ_MASK, 32'hf, 32'h0);
    rchk(8'h40, 32'hffff_ffff, 32'h0);
    chk({30'h0, resp}, 32'h2);
    wr(8'h40, 32'h1);
    chk({30'h0, resp}, 32'h2);
    for (i = 0; i < 5; i++) wr(8'(4 + i * 4), tmr[i]);
    rchk(`AR_OFS_BLOCK, 32'hffff, 32'd20);
    tend("reset");
    wr(`AR_OFS_CTRL, 32'h5);
    flt(3'h2, 1'b1);
    wobs(11'h017, 11'h002);
    flt(3'h0, 1'b0);
    wobs(11'h020, 11'h020);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    wr(`AR_OFS_IRQ_MASK, 32'hf);
    wobs(11'h080, 11'h080);
    rchk(`AR_OFS_IRQ_ST, 32'hf, 32'h1);
    to_idle();
    tend("single pole");
    wr(`AR_OFS_CTRL, 32'hd);
    flt(3'h3, 1'b0);
    wobs(11'h017, 11'h003);
    flt(3'h0, 1'b0);
    wobs(11'h020, 11'h020);
    to_idle();
    tend("two phase");
    wr(`AR_OFS_CTRL, 32'h1);
    flt(3'h1, 1'b1);
    wobs(11'h017, 11'h007);
    flt(3'h0, 1'b0);
    wobs(11'h020, 11'h020);
    wobs(11'h020, 11'h000);
    flt(3'h1, 1'b1);
    wobs(11'h017, 11'h017);
    flt(3'h0, 1'b0);
    wobs(11'h040, 11'h040);
    unblk();
    tend("three pole");
    wr(`AR_OFS_CTRL, 32'h3);
    flt(3'h3, 1'b1);
    wobs(11'h017, 11'h017);
    flt(3'h0, 1'b0);
    wobs(11'h040, 11'h040);
    unblk();
    tend("multi phase");
    wr(`AR_OFS_CTRL, 32'h705);
    for (k = 0; k < 8; k++)
    begin
      flt(3'h4, 1'b1);
      wobs(11'h017, 11'h004);
      flt(3'h0, 1'b0);
      wobs(11'h020, 11'h020);
      wobs(11'h020, 11'h000);
    end
    flt(3'h4, 1'b1);
    wobs(11'h017, 11'h017);
    flt(3'h0, 1'b0);
    wobs(11'h040, 11'h040);
    unblk();
    tend("eight shots");
    wr(`AR_OFS_CTRL, 32'h21);
    for (i = 0; i < 3; i++)
    begin
      flt(3'((1 << (i + 1)) - 1), 1'b1);
      wobs(11'h007, 11'h007);
      flt(3'h0, 1'b0);
      n = 0;
      while (!close_cmd && n < 400)
      begin
        @(posedge sys_clk);
        n++;
      end
      chk(32'(n >= tmr[i] * TICK - TICK && n <= tmr[i] * TICK + 20), 32'h1);
      to_idle();
    end
    tend("pickup dead times");
    wr(`AR_OFS_DEAD1P, 32'd14);
    wr(`AR_OFS_CTRL, 32'h15);
    flt(3'h1, 1'b1);
    wobs(11'h017, 11'h001);
    flt(3'h0, 1'b0);
    repeat (8) @(posedge sys_clk);
    reclose_block <= 1'b1;
    wobs(11'h017, 11'h017);
    reclose_block <= 1'b0;
    wobs(11'h040, 11'h040);
    unblk();
    tend("forced trip");
    wr(`AR_OFS_CTRL, 32'h43);
    charged <= 1'b0;
    flt(3'h1, 1'b1);
    wobs(11'h017, 11'h017);
    charged <= 1'b1;
    flt(3'h0, 1'b0);
    wobs(11'h040, 11'h040);
    unblk();
    fault_in_ar_stage <= 1'b0;
    flt(3'h1, 1'b1);
    wobs(11'h017, 11'h017);
    flt(3'h0, 1'b0);
    wobs(11'h017, 11'h000);
    chk({31'h0, dyn_blocked}, 32'h0);
    fault_in_ar_stage <= 1'b1;
    unblk();
    tend("not ready");
    end_sim();
  end
endmodule

//--- verilog/auto_reclose_sequencer.sv
// Automatic reclose sequencer with AXI4-Lite register slave and interrupt
`include "reclose_cfg.svh"
module auto_reclose_sequencer #(
  parameter int TICK_CYC = `AR_TICK_US * `AR_CLK_MHZ
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  fault_phase,
  input  wire logic        fault_earth,
  input  wire logic        fault_in_ar_stage,
  input  wire logic [2:0]  pole_open,
  input  wire logic        cb_ready,
  input  wire logic        reclose_block,
  output logic [2:0]       trip_pole,
  output logic             final_trip,
  output logic             close_cmd,
  output logic             dyn_blocked,
  output logic             irq
);

  generate
    if (TICK_CYC < 2)
      $error("TICK_CYC must be at least 2");
  endgenerate

  localparam int TW = $clog2(TICK_CYC);

  // Number of phases picked up
  function automatic logic [1:0] n_ph(input logic [2:0] p);
    n_ph = 2'(p[0]) + 2'(p[1]) + 2'(p[2]);
  endfunction

  // Byte-lane merge for partial writes
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      wmerge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
  endfunction

  // Timer load never below one tick
  function automatic reclose_pkg::ticks_t tload(input reclose_pkg::ticks_t v);
    tload = (v == 16'h0000) ? 16'h0001 : v;
  endfunction

  // Pin inputs cross into the clock domain through two flip-flops
  logic [9:0] sync1_r;
  logic [9:0] sync2_r;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync1_r <= 10'h000;
      sync2_r <= 10'h000;
    end
    else
    begin
      sync1_r <= {reclose_block, cb_ready, pole_open, fault_in_ar_stage,
                  fault_earth, fault_phase};
      sync2_r <= sync1_r;
    end
  end

  logic [2:0] flt;
  logic       earth;
  logic       in_stage;
  logic [2:0] popen;
  logic       cb_rdy;
  logic       blk_in;
  assign flt      = sync2_r[2:0];
  assign earth    = sync2_r[3];
  assign in_stage = sync2_r[4];
  assign popen    = sync2_r[7:5];
  assign cb_rdy   = sync2_r[8];
  assign blk_in   = sync2_r[9];

  // Register file
  logic [31:0]          ctrl_r;
  reclose_pkg::ticks_t  dead1p_r;
  reclose_pkg::ticks_t  dead2ph_r;
  reclose_pkg::ticks_t  dead3p_r;
  reclose_pkg::ticks_t  block_r;
  reclose_pkg::ticks_t  reclaim_r;
  logic [3:0]           irq_st_r;
  logic [3:0]           irq_mask_r;
  logic                 unblock_r;
  logic [3:0]           ev_r;

  // Common tick for all sequence timers
  logic [TW-1:0] tick_cnt_r;
  logic          tick;
  assign tick = (tick_cnt_r == '0);
  always_ff @(posedge sys_clk)
  begin
    if (rst || tick)
      tick_cnt_r <= TW'(TICK_CYC - 1);
    else
      tick_cnt_r <= tick_cnt_r - 1'b1;
  end

  // Sequencer
  reclose_pkg::seq_state_t state_r;
  reclose_pkg::ticks_t     tmr_r;
  logic                    cyc1p_r;
  logic                    blk_after_r;
  logic [3:0]              shot_r;
  logic [1:0]              nph_r;
  logic [1:0]              mode;
  logic                    ready;
  logic                    single_ok;
  logic                    allow_3p;
  logic                    expired;
  logic                    more_shots;
  reclose_pkg::ticks_t     dead_val;

  assign mode = ctrl_r[`AR_CTRL_MODE];
  // Reclosure ready: enabled, not blocked, breaker fully closed, fault in the reclose stage
  assign ready = ctrl_r[`AR_CTRL_EN] && !dyn_blocked && !blk_in && (popen == 3'h0) &&
                 in_stage;
  // Single-pole only for the selected modes; combined mode needs its own code
  assign single_ok = (mode == `AR_MODE_1P || mode == `AR_MODE_13P) &&
                     ((n_ph(flt) == 2'd1) ||
                      (n_ph(flt) == 2'd2 && !earth && ctrl_r[`AR_CTRL_TP2]));
  // Single-pole-only mode never recloses after a three-pole trip
  assign allow_3p = (mode != `AR_MODE_1P);
  assign expired  = (tmr_r == 16'h0000);
  // Shot limit is field plus one, so at most eight
  assign more_shots = shot_r < ({1'b0, ctrl_r[`AR_CTRL_SHOTS]} + 4'h1);

  // Dead time by cycle type, or by fault type latched at the trip (pickup may be gone)
  always_comb
  begin
    if (cyc1p_r)
      dead_val = dead1p_r;
    else if (!ctrl_r[`AR_CTRL_PICKUP])
      dead_val = dead3p_r;
    else if (nph_r == 2'd1)
      dead_val = dead1p_r;
    else if (nph_r == 2'd2)
      dead_val = dead2ph_r;
    else
      dead_val = dead3p_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r     <= reclose_pkg::ST_IDLE;
      tmr_r       <= 16'h0000;
      cyc1p_r     <= 1'b0;
      blk_after_r <= 1'b0;
      shot_r      <= 4'h0;
      nph_r       <= 2'h0;
      trip_pole   <= 3'h0;
      final_trip  <= 1'b0;
      close_cmd   <= 1'b0;
      dyn_blocked <= 1'b0;
      ev_r        <= 4'h0;
    end
    else
    begin
      ev_r <= 4'h0;
      if (tick && !expired)
        tmr_r <= tmr_r - 16'h0001;
      // Close coil released once all poles report closed
      if (popen == 3'h0)
        close_cmd <= 1'b0;
      case (state_r)
        reclose_pkg::ST_IDLE:
        begin
          tmr_r  <= 16'h0000;
          shot_r <= 4'h0;
          if (flt != 3'h0)
          begin
            // Breaker must manage open-close-open at the first trip
            if (ready && (cb_rdy || !ctrl_r[`AR_CTRL_CBCHK]) &&
                (single_ok || allow_3p))
            begin
              state_r   <= reclose_pkg::ST_TRIP;
              cyc1p_r   <= single_ok;
              nph_r     <= n_ph(flt);
              trip_pole <= single_ok ? flt : 3'h7;
            end
            else
            begin
              // Not reclosable: three-pole trip with the stage without reclosure
              state_r     <= reclose_pkg::ST_FINAL;
              blk_after_r <= ready;
              trip_pole   <= 3'h7;
              final_trip  <= 1'b1;
              ev_r[`AR_IRQ_FINAL] <= 1'b1;
            end
          end
        end
        reclose_pkg::ST_TRIP:
        begin
          // Dead time starts on trip reset or pole opening
          if (flt == 3'h0 || (popen & trip_pole) != 3'h0)
          begin
            state_r   <= reclose_pkg::ST_DEAD;
            trip_pole <= 3'h0;
            tmr_r     <= tload(dead_val);
          end
        end
        reclose_pkg::ST_DEAD:
        begin
          if (blk_in)
          begin
            if (cyc1p_r && ctrl_r[`AR_CTRL_FORCE3P])
            begin
              // Avoids leaving the breaker open on one pole
              state_r     <= reclose_pkg::ST_FINAL;
              blk_after_r <= 1'b1;
              trip_pole   <= 3'h7;
              final_trip  <= 1'b1;
              ev_r[`AR_IRQ_FINAL] <= 1'b1;
            end
            else
            begin
              state_r     <= reclose_pkg::ST_BLOCKED;
              dyn_blocked <= 1'b1;
              ev_r[`AR_IRQ_BLOCK] <= 1'b1;
            end
          end
          else if (expired)
          begin
            // Close and supervision timer start together
            state_r   <= reclose_pkg::ST_POST;
            close_cmd <= 1'b1;
            tmr_r     <= tload(cyc1p_r ? block_r : reclaim_r);
            shot_r    <= shot_r + 4'h1;
            ev_r[`AR_IRQ_CLOSE] <= 1'b1;
          end
        end
        reclose_pkg::ST_POST:
        begin
          if (flt != 3'h0)
          begin
            close_cmd <= 1'b0;
            if (more_shots && !blk_in && (single_ok || allow_3p))
            begin
              state_r   <= reclose_pkg::ST_TRIP;
              cyc1p_r   <= single_ok;
              nph_r     <= n_ph(flt);
              trip_pole <= single_ok ? flt : 3'h7;
            end
            else
            begin
              // Fault while supervision timer runs and no further shot allowed: final three-pole trip
              state_r     <= reclose_pkg::ST_FINAL;
              blk_after_r <= 1'b1;
              trip_pole   <= 3'h7;
              final_trip  <= 1'b1;
              ev_r[`AR_IRQ_FINAL] <= 1'b1;
            end
          end
          else if (expired)
          begin
            state_r <= reclose_pkg::ST_IDLE;
            cyc1p_r <= 1'b0;
            ev_r[`AR_IRQ_DONE] <= 1'b1;
          end
        end
        reclose_pkg::ST_FINAL:
        begin
          tmr_r <= 16'h0000;
          if (flt == 3'h0)
          begin
            trip_pole   <= 3'h0;
            final_trip  <= 1'b0;
            blk_after_r <= 1'b0;
            if (blk_after_r)
            begin
              state_r     <= reclose_pkg::ST_BLOCKED;
              dyn_blocked <= 1'b1;
              ev_r[`AR_IRQ_BLOCK] <= 1'b1;
            end
            else
              state_r <= reclose_pkg::ST_IDLE;
          end
        end
        reclose_pkg::ST_BLOCKED:
        begin
          tmr_r <= 16'h0000;
          // A new fault while blocked is tripped three-pole without reclosure
          trip_pole  <= (flt != 3'h0) ? 3'h7 : 3'h0;
          final_trip <= (flt != 3'h0);
          if (unblock_r)
          begin
            state_r     <= reclose_pkg::ST_IDLE;
            dyn_blocked <= 1'b0;
          end
        end
        default:
          state_r <= reclose_pkg::ST_IDLE;
      endcase
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  logic        aw_have_r;
  logic        w_have_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_go;
  logic        wr_hit;
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  always_comb
  begin
    case (awaddr_r)
      `AR_OFS_CTRL, `AR_OFS_DEAD1P, `AR_OFS_DEAD2PH, `AR_OFS_DEAD3P, `AR_OFS_BLOCK,
      `AR_OFS_RECLAIM, `AR_OFS_STATUS, `AR_OFS_IRQ_ST, `AR_OFS_IRQ_MASK, `AR_OFS_CMD:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers; status is read-only
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_r     <= `AR_CTRL_RST;
      dead1p_r   <= `AR_TIME_RST;
      dead2ph_r  <= `AR_TIME_RST;
      dead3p_r   <= `AR_TIME_RST;
      block_r    <= `AR_TIME_RST;
      reclaim_r  <= `AR_TIME_RST;
      irq_mask_r <= 4'h0;
      unblock_r  <= 1'b0;
    end
    else
    begin
      unblock_r <= 1'b0;
      if (wr_go)
      begin
        case (awaddr_r)
          `AR_OFS_CTRL:     ctrl_r     <= wmerge(ctrl_r, wdata_r, wstrb_r);
          `AR_OFS_DEAD1P:   dead1p_r   <= 16'(wmerge({16'h0, dead1p_r}, wdata_r, wstrb_r));
          `AR_OFS_DEAD2PH:  dead2ph_r  <= 16'(wmerge({16'h0, dead2ph_r}, wdata_r, wstrb_r));
          `AR_OFS_DEAD3P:   dead3p_r   <= 16'(wmerge({16'h0, dead3p_r}, wdata_r, wstrb_r));
          `AR_OFS_BLOCK:    block_r    <= 16'(wmerge({16'h0, block_r}, wdata_r, wstrb_r));
          `AR_OFS_RECLAIM:  reclaim_r  <= 16'(wmerge({16'h0, reclaim_r}, wdata_r, wstrb_r));
          `AR_OFS_IRQ_MASK: irq_mask_r <= wstrb_r[0] ? wdata_r[3:0] : irq_mask_r;
          `AR_OFS_CMD:      unblock_r  <= wstrb_r[0] & wdata_r[0];
          default:          unblock_r  <= 1'b0;
        endcase
      end
    end
  end

  // Sticky event bits: write one clears, a new event in the same cycle wins
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      irq_st_r <= 4'h0;
      irq      <= 1'b0;
    end
    else
    begin
      if (wr_go && awaddr_r == `AR_OFS_IRQ_ST && wstrb_r[0])
        irq_st_r <= (irq_st_r & ~wdata_r[3:0]) | ev_r;
      else
        irq_st_r <= irq_st_r | ev_r;
      irq <= |(irq_st_r & irq_mask_r);
    end
  end

  // AXI4-Lite read path: one read at a time, data one cycle after the address
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `AR_OFS_CTRL:     rd_mux = ctrl_r;
      `AR_OFS_DEAD1P:   rd_mux = {16'h0000, dead1p_r};
      `AR_OFS_DEAD2PH:  rd_mux = {16'h0000, dead2ph_r};
      `AR_OFS_DEAD3P:   rd_mux = {16'h0000, dead3p_r};
      `AR_OFS_BLOCK:    rd_mux = {16'h0000, block_r};
      `AR_OFS_RECLAIM:  rd_mux = {16'h0000, reclaim_r};
      `AR_OFS_STATUS:   rd_mux = {tmr_r, 4'h0, shot_r, final_trip, close_cmd,
                                  dyn_blocked, cyc1p_r, 1'b0, state_r};
      `AR_OFS_IRQ_ST:   rd_mux = {28'h0000000, irq_st_r};
      `AR_OFS_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_r};
      `AR_OFS_CMD:      rd_mux = 32'h0000_0000;
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- verilog/reclose_cfg.svh
// Register map, field positions, reset values and timing for the reclose sequencer
// Functional notes
// - Pickup start: dead time chosen by fault type
// - Success: reclaim runs out, back to idle
// - Fault during reclaim gives final trip once the shots are used up
// - Final trip leaves reclosure dynamically blocked, except from idle while not ready
// - Up to eight reclose shots per sequence
// - Single-pole cycles only if mode selected
// - Single-pole mode: trip faulted pole only
// - Option: single-pole trip for two-phase unearthed
// - Multi-phase fault in single-pole mode: final three-pole trip, block
// - Single-pole-only mode: three-pole trip is final
// - Sequence starts when single-pole trip issued
// - Dead time starts on trip reset or pole open
// - Dead expiry: close and start blocking timer (single-pole) or reclaim timer
// - Blocked in single-pole dead: forced three-pole trip
// - Fault in blocking time after the last shot: final three-pole trip
// - Combined mode only when selected
// - Combined mode: single-pole trip single-phase faults
`ifndef RECLOSE_CFG_SVH
`define RECLOSE_CFG_SVH
`define AR_CLK_MHZ      50
`define AR_TICK_US      1000
`define AR_OFS_CTRL     8'h00
`define AR_OFS_DEAD1P   8'h04
`define AR_OFS_DEAD2PH  8'h08
`define AR_OFS_DEAD3P   8'h0c
`define AR_OFS_BLOCK    8'h10
`define AR_OFS_RECLAIM  8'h14
`define AR_OFS_STATUS   8'h18
`define AR_OFS_IRQ_ST   8'h1c
`define AR_OFS_IRQ_MASK 8'h20
`define AR_OFS_CMD      8'h24
`define AR_CTRL_EN      0
`define AR_CTRL_MODE    2:1
`define AR_CTRL_TP2     3
`define AR_CTRL_FORCE3P 4
`define AR_CTRL_PICKUP  5
`define AR_CTRL_CBCHK   6
`define AR_CTRL_SHOTS   10:8
`define AR_MODE_3P      2'h0
`define AR_MODE_1P      2'h1
`define AR_MODE_13P     2'h2
`define AR_CTRL_RST     32'h0000_0000
`define AR_TIME_RST     16'h0064
`define AR_IRQ_CLOSE    0
`define AR_IRQ_FINAL    1
`define AR_IRQ_DONE     2
`define AR_IRQ_BLOCK    3
`endif

//--- verilog/reclose_pkg.sv
// Types shared by the reclose sequencer
package reclose_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TRIP,
    ST_DEAD,
    ST_POST,
    ST_FINAL,
    ST_BLOCKED
  } seq_state_t;
  typedef logic [15:0] ticks_t;
endpackage
